// file: logic/rtcw_regs.svh
// constants for the transmit subaddress control word
`ifndef RTCW_REGS_SVH
`define RTCW_REGS_SVH
`define RTCW_WIDTH 16
`define RTCW_RESET 16'h0000
`define RTCW_SA_MIN 5'h01
`define RTCW_SA_MAX 5'h1e
`define RTCW_BIT_ALT_REQ 2
`define RTCW_BIT_ACK 8
`define RTCW_BIT_BROADCAST_FLAG 9
`define RTCW_BIT_NEXT_BUF 10
`define RTCW_BIT_TOUCHED 11
`define RTCW_BIT_BUSY 12
`define RTCW_BIT_RSVD 13
`define RTCW_BIT_ACC_IRQ 14
`define RTCW_BIT_CZ_IRQ 15
`define RTCW_MASK_IDLE_WR 16'h00f7
`define RTCW_MASK_ANY_WR 16'hd008
`define RTCW_MASK_SOFT_CLR 16'h0e00
`define RTCW_COUNT_ONE 16'h0001
`endif

// file: logic/rtcw_pkg.sv
// types for the transmit subaddress control word
package rtcw_pkg;
  typedef logic [15:0] rtcw_word_type;
  typedef enum logic [1:0] {RTCW_MODE_INDEX, RTCW_MODE_ALT, RTCW_MODE_CIRC} rtcw_mode_type;
endpackage

// file: logic/rtcw_cmd_match.sv
// decoder of commands that use the transmit control word
`include "rtcw_regs.svh"
module rtcw_cmd_match
  import rtcw_pkg::*;
(
  // command
  input wire logic cmd_valid,
  input wire logic cmd_tx,
  input wire logic [4:0] cmd_subaddr,
  // result
  output logic cmd_hit
);
  assign cmd_hit = cmd_valid && cmd_tx && (cmd_subaddr >= `RTCW_SA_MIN) &&
                   (cmd_subaddr <= `RTCW_SA_MAX);
endmodule // rtcw_cmd_match

// file: logic/rtcw_irq_gate.sv
// gating of the two subaddress interrupt events
module rtcw_irq_gate
  import rtcw_pkg::*;
(
  // inputs
  input wire logic done,
  input wire logic acc_en_local,
  input wire logic acc_en_global,
  input wire logic cz_en_local,
  input wire logic cz_en_global,
  input wire logic count_reached,
  // events
  output logic acc_evt,
  output logic cz_evt
);
  assign acc_evt = done && acc_en_local && acc_en_global;
  assign cz_evt = done && count_reached && cz_en_local && cz_en_global;
endmodule // rtcw_irq_gate

// file: logic/rtcw_top.sv
// transmit subaddress control word with host access and engine updates
// ----------------------------------------
// Overview of operation
// - the word is used only for valid transmit commands to subaddress 1 to 30.
// - a word written while the terminal is disabled never gets its ack bit set.
// - host writes to bits 8 to 11 are ignored and the device updates them while running.
// - bits 0 to 2 and 4 to 7 take host writes only while the terminal is not running.
// - bits 3, 12, 14 and 15 take host writes at any time.
// - master reset clears the whole word.
// - soft reset clears only the touched, next-buffer and broadcast bits.
// - a host read of the word clears the touched flag after returning the value.
// - the count-reached interrupt fires when enabled and the count hits zero in index or circular mode, never in alternating mode.
// - an interrupt sets a pending flag, raises the interrupt output and logs an entry.
// - the accessed interrupt fires when enabled at the end of any command that uses the word.
// - the touched flag is set when message processing ends.
// - in alternating mode with the ack bit set, the next-buffer bit flips after each error-free message not answered busy.
// - with busy set the device answers busy, sends no data and keeps the buffer bit.
// ----------------------------------------
`include "rtcw_regs.svh"
module rtcw_top
  import rtcw_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic soft_reset,
  // global configuration
  input wire logic terminal_enable,
  input wire logic terminal_running,
  input wire logic acc_irq_global_en,
  input wire logic cz_irq_global_en,
  // host access
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [15:0] host_wdata,
  output logic [15:0] host_rdata,
  // protocol engine
  input wire logic cmd_valid,
  input wire logic cmd_tx,
  input wire logic cmd_broadcast_flag,
  input wire logic [4:0] cmd_subaddr,
  input wire logic [1:0] buf_mode,
  input wire logic msg_done,
  input wire logic msg_error,
  input wire logic [15:0] message_countdown,
  input wire logic circ_count_done,
  output logic cmd_uses_word,
  output logic busy_response,
  output logic send_data,
  output logic buffer_sel_b,
  // interrupt side
  output logic pend_acc,
  output logic pend_cz,
  output logic irq_out,
  output logic log_push,
  output logic [1:0] log_code
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    rtcw_word_type word;
    logic [15:0] rdata;
    logic act;
    logic busy;
    logic send;
    logic bsel;
    logic p_acc;
    logic p_cz;
    logic irq;
    logic push;
    logic [1:0] code;
    logic was_en;
  } rtcw_state_type;

  rtcw_state_type st_r, st_nxt;
  logic hit, acc_evt, cz_evt, cnt_reached;
  rtcw_mode_type mode;

  function automatic rtcw_word_type merge(rtcw_word_type cur, rtcw_word_type nw,
                                          rtcw_word_type msk);
    merge = (cur & ~msk) | (nw & msk);
  endfunction

  assign mode = rtcw_mode_type'(buf_mode);

  rtcw_cmd_match u_match (
    .cmd_valid(cmd_valid),
    .cmd_tx(cmd_tx),
    .cmd_subaddr(cmd_subaddr),
    .cmd_hit(hit)
  );

  assign cnt_reached = (mode == RTCW_MODE_INDEX) ? (message_countdown == `RTCW_COUNT_ONE)
                     : (mode == RTCW_MODE_CIRC) ? circ_count_done : 1'b0;

  rtcw_irq_gate u_gate (
    .done(msg_done && st_r.act),
    .acc_en_local(st_r.word[`RTCW_BIT_ACC_IRQ]),
    .acc_en_global(acc_irq_global_en),
    .cz_en_local(st_r.word[`RTCW_BIT_CZ_IRQ]),
    .cz_en_global(cz_irq_global_en),
    .count_reached(cnt_reached),
    .acc_evt(acc_evt),
    .cz_evt(cz_evt)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.push = 1'b0;
    st_nxt.irq = 1'b0;
    st_nxt.rdata = st_r.word;
    // touched flag clears once the read value has been handed out
    if (host_rd) begin
      st_nxt.word[`RTCW_BIT_TOUCHED] = 1'b0;
    end
    if (host_wr) begin
      st_nxt.was_en = terminal_enable;
      st_nxt.word = merge(st_nxt.word, host_wdata, `RTCW_MASK_ANY_WR);
      if (!terminal_running) begin
        st_nxt.word = merge(st_nxt.word, host_wdata, `RTCW_MASK_IDLE_WR);
      end
      // bits 8-11 and 13 are never taken from the host
    end
    if (terminal_running && st_r.word[`RTCW_BIT_ALT_REQ]) begin
      st_nxt.word[`RTCW_BIT_ACK] = st_r.was_en;
    end
    if (hit) begin
      st_nxt.act = 1'b1;
      st_nxt.busy = st_r.word[`RTCW_BIT_BUSY];
      st_nxt.send = !st_r.word[`RTCW_BIT_BUSY];
      st_nxt.bsel = st_r.word[`RTCW_BIT_NEXT_BUF];
      if (terminal_running) begin
        st_nxt.word[`RTCW_BIT_BROADCAST_FLAG] = cmd_broadcast_flag;
      end
    end
    if (msg_done && st_r.act && terminal_running) begin
      st_nxt.act = 1'b0;
      st_nxt.send = 1'b0;
      st_nxt.busy = 1'b0;
      // set wins over a read clear in the same cycle
      st_nxt.word[`RTCW_BIT_TOUCHED] = 1'b1;
      if (mode == RTCW_MODE_ALT && st_r.word[`RTCW_BIT_ACK] && !msg_error && !st_r.busy) begin
        st_nxt.word[`RTCW_BIT_NEXT_BUF] = !st_r.word[`RTCW_BIT_NEXT_BUF];
      end
    end
    if (acc_evt || cz_evt) begin
      st_nxt.p_acc = st_r.p_acc | acc_evt;
      st_nxt.p_cz = st_r.p_cz | cz_evt;
      st_nxt.irq = 1'b1;
      st_nxt.push = 1'b1;
      st_nxt.code = {cz_evt, acc_evt};
    end
    if (soft_reset) begin
      st_nxt.word = st_nxt.word & ~`RTCW_MASK_SOFT_CLR;
    end
    st_nxt.word[`RTCW_BIT_RSVD] = 1'b0;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign host_rdata = st_r.rdata;
  assign cmd_uses_word = st_r.act;
  assign busy_response = st_r.busy;
  assign send_data = st_r.send;
  assign buffer_sel_b = st_r.bsel;
  assign pend_acc = st_r.p_acc;
  assign pend_cz = st_r.p_cz;
  assign irq_out = st_r.irq;
  assign log_push = st_r.push;
  assign log_code = st_r.code;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_reserved_zero;
    @(posedge core_clk) disable iff (!rst_n) st_r.word[`RTCW_BIT_RSVD] == 1'b0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_read_clears;
    @(posedge core_clk) disable iff (!rst_n)
      clk_en && host_rd && !(msg_done && st_r.act && terminal_running)
      |=> !st_r.word[`RTCW_BIT_TOUCHED];
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("touched flag not cleared");

  property p_status_locked;
    @(posedge core_clk) disable iff (!rst_n)
      clk_en && host_wr && !terminal_running && !msg_done && !hit && !soft_reset && !host_rd
      |=> st_r.word[11:8] == $past(st_r.word[11:8]);
  endproperty
  a_status_locked: assert property (p_status_locked) else $error("host wrote status bits");

  property p_idle_write;
    @(posedge core_clk) disable iff (!rst_n)
      clk_en && host_wr && !terminal_running |=> st_r.word[7:4] == $past(host_wdata[7:4]);
  endproperty
  a_idle_write: assert property (p_idle_write) else $error("idle write lost");

  property p_run_write_blocked;
    @(posedge core_clk) disable iff (!rst_n)
      clk_en && host_wr && terminal_running && !soft_reset
      |=> st_r.word[7:4] == $past(st_r.word[7:4]);
  endproperty
  a_run_write_blocked: assert property (p_run_write_blocked) else $error("run write taken");

  property p_any_write;
    @(posedge core_clk) disable iff (!rst_n)
      clk_en && host_wr |=> st_r.word[15:14] == $past(host_wdata[15:14]);
  endproperty
  a_any_write: assert property (p_any_write) else $error("irq enables not written");

  property p_soft_reset;
    @(posedge core_clk) disable iff (!rst_n)
      clk_en && soft_reset |=> st_r.word[11:9] == 3'b000;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset missed");

  sequence s_irq_evt;
    clk_en && (acc_evt || cz_evt);
  endsequence
  property p_irq_log;
    @(posedge core_clk) disable iff (!rst_n) s_irq_evt |=> irq_out && log_push;
  endproperty
  a_irq_log: assert property (p_irq_log) else $error("interrupt not raised");

  property p_busy_no_data;
    @(posedge core_clk) disable iff (!rst_n) busy_response |-> !send_data;
  endproperty
  a_busy_no_data: assert property (p_busy_no_data) else $error("data sent while busy");

  property p_hit_range;
    @(posedge core_clk) disable iff (!rst_n)
      clk_en && cmd_valid && cmd_tx && cmd_subaddr == 5'h00 && !st_r.act |=> !st_r.act;
  endproperty
  a_hit_range: assert property (p_hit_range) else $error("subaddress zero used word");

  // ----------------------------------------
  // message end checks
  // ----------------------------------------
  sequence s_msg_end;
    clk_en && msg_done && st_r.act && terminal_running && !soft_reset;
  endsequence

  property p_touched_set;
    @(posedge core_clk) disable iff (!rst_n) s_msg_end |=> st_r.word[`RTCW_BIT_TOUCHED];
  endproperty
  a_touched_set: assert property (p_touched_set) else $error("touched not set");

  sequence s_clean_alt_end;
    s_msg_end ##0 (mode == RTCW_MODE_ALT && st_r.word[`RTCW_BIT_ACK] &&
      !msg_error && !st_r.busy);
  endsequence

  property p_next_buf_flip;
    @(posedge core_clk) disable iff (!rst_n)
      s_clean_alt_end
      |=> st_r.word[`RTCW_BIT_NEXT_BUF] != $past(st_r.word[`RTCW_BIT_NEXT_BUF]);
  endproperty
  a_next_buf_flip: assert property (p_next_buf_flip) else $error("no flip");

  // a failed or busy message must not move the host onto the other buffer
  property p_buf_held;
    @(posedge core_clk) disable iff (!rst_n)
      s_msg_end ##0 (msg_error || st_r.busy)
      |=> st_r.word[`RTCW_BIT_NEXT_BUF] == $past(st_r.word[`RTCW_BIT_NEXT_BUF]);
  endproperty
  a_buf_held: assert property (p_buf_held) else $error("buffer bit moved");

  property p_busy_answer;
    @(posedge core_clk) disable iff (!rst_n)
      clk_en && hit && st_r.word[`RTCW_BIT_BUSY] && !msg_done |=> busy_response && !send_data;
  endproperty
  a_busy_answer: assert property (p_busy_answer) else $error("busy not answered");

  property p_ack_follows;
    @(posedge core_clk) disable iff (!rst_n)
      clk_en && terminal_running && st_r.word[`RTCW_BIT_ALT_REQ]
      |=> st_r.word[`RTCW_BIT_ACK] == $past(st_r.was_en);
  endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("ack wrong");

  property p_broadcast_flag_copy;
    @(posedge core_clk) disable iff (!rst_n)
      clk_en && hit && terminal_running && !soft_reset
      |=> st_r.word[`RTCW_BIT_BROADCAST_FLAG] == $past(cmd_broadcast_flag);
  endproperty
  a_broadcast_flag_copy: assert property (p_broadcast_flag_copy) else $error("broadcast not copied");

  property p_any_write_busy;
    @(posedge core_clk) disable iff (!rst_n)
      clk_en && host_wr |=> st_r.word[`RTCW_BIT_BUSY] == $past(host_wdata[`RTCW_BIT_BUSY]);
  endproperty
  a_any_write_busy: assert property (p_any_write_busy) else $error("busy not written");

  // ----------------------------------------
  // interrupt checks
  // ----------------------------------------
  sequence s_count_hit;
    clk_en && msg_done && st_r.act && mode == RTCW_MODE_INDEX &&
      message_countdown == `RTCW_COUNT_ONE;
  endsequence

  property p_cz_index;
    @(posedge core_clk) disable iff (!rst_n)
      s_count_hit ##0 (st_r.word[`RTCW_BIT_CZ_IRQ] && cz_irq_global_en)
      |=> pend_cz && log_push && log_code[1];
  endproperty
  a_cz_index: assert property (p_cz_index) else $error("count irq missed");

  property p_acc_irq;
    @(posedge core_clk) disable iff (!rst_n)
      clk_en && msg_done && st_r.act && st_r.word[`RTCW_BIT_ACC_IRQ] && acc_irq_global_en
      |=> pend_acc && irq_out && log_code[0];
  endproperty
  a_acc_irq: assert property (p_acc_irq) else $error("access irq missed");

  // pending flags have no clear input, so only master reset may drop them
  property p_pend_sticky;
    @(posedge core_clk) disable iff (!rst_n)
      pend_acc || pend_cz |=> (pend_acc || !$past(pend_acc)) && (pend_cz || !$past(pend_cz));
  endproperty
  a_pend_sticky: assert property (p_pend_sticky) else $error("pending flag lost");

  property p_master_clear;
    @(posedge core_clk) $rose(rst_n) |-> st_r.word == `RTCW_RESET && !pend_acc && !pend_cz;
  endproperty
  a_master_clear: assert property (p_master_clear) else $error("reset left state");
endmodule // rtcw_top

// file: verification/rtcw_host_model.sv
// host processor model for the control word access port
module rtcw_host_model (
  // clock
  input wire logic core_clk,
  // host access
  output logic host_wr,
  output logic host_rd,
  output logic [15:0] host_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_wdata = 16'h0000;
  end
  // words are written with a one-cycle strobe, whether the terminal is running or not
  task automatic wr(input logic [15:0] d);
    @(negedge core_clk);
    host_wr = 1'b1;
    host_wdata = d;
    @(negedge core_clk);
    host_wr = 1'b0;
    // idle bus shows the inverse so a stale value is never mistaken for data
    host_wdata = ~d;
  endtask
  task automatic rd();
    @(negedge core_clk);
    host_rd = 1'b1;
    @(negedge core_clk);
    host_rd = 1'b0;
  endtask
endmodule // rtcw_host_model

// file: verification/rtcw_top_tb.sv
// self-checking bench for the transmit subaddress control word
`define CHK(a, b) chk(16'(a), 16'(b));
module rtcw_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, rst_n, soft_reset, terminal_enable, terminal_running;
  logic acc_irq_global_en, cz_irq_global_en, host_wr, host_rd;
  logic [15:0] host_wdata, host_rdata, message_countdown;
  logic cmd_valid, cmd_tx, cmd_broadcast_flag, msg_done, rd_d;
  logic clk_en, msg_error, circ_count_done;
  logic [1:0] irq_q[$];
  logic [4:0] cmd_subaddr, sa;
  logic [1:0] buf_mode, log_code;
  logic cmd_uses_word, busy_response, send_data, buffer_sel_b;
  logic pend_acc, pend_cz, irq_out, log_push;
  logic [15:0] exp_q[$];
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  // ----------------------------------------
  // clock, design and host
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  rtcw_top DUT (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .soft_reset(soft_reset),
    .terminal_enable(terminal_enable), .terminal_running(terminal_running),
    .acc_irq_global_en(acc_irq_global_en), .cz_irq_global_en(cz_irq_global_en),
    .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .cmd_valid(cmd_valid), .cmd_tx(cmd_tx), .cmd_broadcast_flag(cmd_broadcast_flag), .cmd_subaddr(cmd_subaddr),
    .buf_mode(buf_mode), .msg_done(msg_done), .msg_error(msg_error),
    .message_countdown(message_countdown), .circ_count_done(circ_count_done),
    .cmd_uses_word(cmd_uses_word), .busy_response(busy_response), .send_data(send_data),
    .buffer_sel_b(buffer_sel_b), .pend_acc(pend_acc), .pend_cz(pend_cz), .irq_out(irq_out),
    .log_push(log_push), .log_code(log_code));
  rtcw_host_model HOST (.core_clk(core_clk), .host_wr(host_wr), .host_rd(host_rd),
    .host_wdata(host_wdata));
  // ----------------------------------------
  // checking
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // read data stands one cycle after the request
  always @(posedge core_clk) begin
    rd_d <= host_rd;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      final_report();
    end
  end
  always @(negedge core_clk) begin
    if (rd_d === 1'b1) begin
      `CHK(host_rdata, exp_q.pop_front())
    end
  end
  // each log entry is matched against the oldest expected interrupt code
  always @(negedge core_clk) begin
    if (log_push === 1'b1) begin
      if (irq_q.size() == 0) begin
        `CHK(log_push, 1'b0)
      end else begin
        `CHK(log_code, irq_q.pop_front())
        `CHK(irq_out, 1'b1)
      end
    end
  end
  task automatic rdx(input logic [15:0] e);
    exp_q.push_back(e);
    HOST.rd();
  endtask
  task automatic cmd(input logic [4:0] s, input logic tx, input logic hit, input logic busy,
    input logic [1:0] code);
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_tx = tx;
    cmd_subaddr = s;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    `CHK(cmd_uses_word, hit)
    if (hit) begin
      `CHK(busy_response, busy)
      `CHK(send_data, !busy)
      if (code != 2'b00) begin
        irq_q.push_back(code);
      end
      msg_done = 1'b1;
      @(negedge core_clk);
      msg_done = 1'b0;
    end
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {rst_n, soft_reset, terminal_running, cmd_valid, cmd_tx, cmd_broadcast_flag, msg_done} = '0;
    {msg_error, circ_count_done} = 2'b00;
    {clk_en, terminal_enable, acc_irq_global_en, cz_irq_global_en} = 4'b1111;
    {cmd_subaddr, buf_mode, message_countdown} = '0;
    void'($urandom(87));
    repeat (5) @(negedge core_clk);
    rst_n = 1'b1;
    rdx(16'h0000);
    HOST.wr(16'hffff);
    rdx(16'hd0ff);
    $display("test access idle done");
    terminal_running = 1'b1;
    HOST.wr(16'h0000);
    rdx(16'h01f7);
    HOST.wr(16'hc000);
    rdx(16'hc1f7);
    buf_mode = 2'd1;
    sa = 5'(1 + ($urandom % 30));
    cmd(sa, 1'b1, 1'b1, 1'b0, 2'b01);
    `CHK(pend_acc, 1'b1)
    `CHK(buffer_sel_b, 1'b0)
    rdx(16'hcdf7);
    rdx(16'hc5f7);
    $display("test message done");
    HOST.wr(16'hd000);
    {buf_mode, message_countdown, cmd_broadcast_flag} = {2'd0, 16'h0001, 1'b1};
    cmd(sa, 1'b1, 1'b1, 1'b1, 2'b11);
    `CHK(pend_cz, 1'b1)
    `CHK(buffer_sel_b, 1'b1)
    rdx(16'hdff7);
    $display("test busy done");
    HOST.wr(16'hc000);
    {buf_mode, msg_error} = {2'd1, 1'b1};
    cmd(sa, 1'b1, 1'b1, 1'b0, 2'b01);
    `CHK(buffer_sel_b, 1'b1)
    {buf_mode, msg_error, circ_count_done} = {2'd2, 1'b0, 1'b1};
    cmd(sa, 1'b1, 1'b1, 1'b0, 2'b11);
    circ_count_done = 1'b0;
    rdx(16'hcff7);
    $display("test error and circular done");
    cmd(5'h00, 1'b1, 1'b0, 1'b0, 2'b00);
    cmd(5'h1f, 1'b1, 1'b0, 1'b0, 2'b00);
    cmd(sa, 1'b0, 1'b0, 1'b0, 2'b00);
    $display("test miss done");
    @(negedge core_clk);
    soft_reset = 1'b1;
    @(negedge core_clk);
    soft_reset = 1'b0;
    rdx(16'hc1f7);
    $display("test soft reset done");
    @(negedge core_clk);
    rst_n = 1'b0;
    @(negedge core_clk);
    rst_n = 1'b1;
    rdx(16'h0000);
    `CHK(pend_acc, 1'b0)
    $display("test master reset done");
    {terminal_running, terminal_enable} = 2'b00;
    HOST.wr(16'h0004);
    {terminal_running, terminal_enable} = 2'b11;
    rdx(16'h0004);
    clk_en = 1'b0;
    HOST.wr(16'hc000);
    clk_en = 1'b1;
    rdx(16'h0004);
    `CHK(irq_q.size(), 0)
    $display("test disabled write done");
    final_report();
  end
endmodule // rtcw_top_tb
